// file: core/wdg_regs.vh
`ifndef WDG_REGS_VH
`define WDG_REGS_VH

// ==========================================================
// register map
`define WDG_CTRL_ADDR 8'h2a
`define WDG_CTRL_RESET 8'h7f
`define WDG_ACT_BIT 7
`define WDG_TOP_BIT 6
`define WDG_EXPIRE_VAL 7'h40

// ==========================================================
// time base
`define WDG_TICK_CYCLES 16384
`define WDG_LSB_OFFSET 128
`define WDG_MIN_UNIT_SHIFT 8
`define WDG_LSB_TB0 59
`define WDG_LSB_TB1 53
`define WDG_LSB_TB2 35
`define WDG_LSB_TB3 54

// ==========================================================
// timing
`define WDG_CLK_PERIOD_NS 8
`define WDG_RST_PULSE_NS 30000
`define WDG_RST_PULSE_CYC (`WDG_RST_PULSE_NS / `WDG_CLK_PERIOD_NS)
`define WDG_RESTART_SHORT 256
`define WDG_RESTART_LONG 4096

`endif

// file: core/wdg_reset_stretch.v
`include "wdg_regs.vh"

module wdg_reset_stretch #(
  parameter LENGTH = `WDG_RST_PULSE_CYC
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // request
  input wire trigger_i,
  // pin drive
  output wire active_o
);

  reg [11:0] remain_reg;
  reg [11:0] remain_next;

  // ==========================================================
  // holds the pin low for a fixed time; retriggers are absorbed
  always @*
  begin
    remain_next = remain_reg;
    if (remain_reg != 12'h000)
      remain_next = remain_reg - 12'h001;
    else if (trigger_i)
      remain_next = LENGTH[11:0];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      remain_reg <= 12'h000;
    else
      remain_reg <= remain_next;
  end

  assign active_o = (remain_reg != 12'h000);

endmodule // wdg_reset_stretch

// file: core/wdg_time_base.v
`include "wdg_regs.vh"

module wdg_time_base #(
  parameter TICK_CYCLES = `WDG_TICK_CYCLES
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // control
  input wire run_i,
  input wire reload_i,
  input wire [1:0] time_base_sel_i,
  // output
  output wire tick_o
);

  reg [14:0] count_reg;
  reg [14:0] count_next;
  reg [31:0] lsb;
  wire [31:0] min_first;
  wire [14:0] limit;
  wire [14:0] last;

  // ==========================================================
  // least time before the first decrement after a reload
  always @*
  begin
    case (time_base_sel_i)
      2'h0: lsb = `WDG_LSB_TB0;
      2'h1: lsb = `WDG_LSB_TB1;
      2'h2: lsb = `WDG_LSB_TB2;
      default: lsb = `WDG_LSB_TB3;
    endcase
  end

  // (lsb+128)*64 of 16384, scaled to the tick period
  assign min_first = ((lsb + `WDG_LSB_OFFSET) * TICK_CYCLES) >> `WDG_MIN_UNIT_SHIFT;
  assign limit = TICK_CYCLES[14:0] - min_first[14:0];
  assign last = TICK_CYCLES[14:0] - 15'h0001;

  // ==========================================================
  // free-running divider, frozen while the oscillator is stopped
  always @*
  begin
    count_next = count_reg;
    if (run_i)
    begin
      if (count_reg == last)
        count_next = 15'h0000;
      else
        count_next = count_reg + 15'h0001;
    end
    if (reload_i && (count_next > limit))
      count_next = limit;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      count_reg <= 15'h0000;
    else
      count_reg <= count_next;
  end

  assign tick_o = run_i && (count_reg == last);

endmodule // wdg_time_base

// file: core/windowed_watchdog_timer.v
// Notes on behaviour
// - counter decrements once per 16384 oscillator cycles
// - active watchdog resets on 40h to 3Fh
// - activate bit set by write, cleared by reset
// - no timeout reset while activate bit clear, unless hardware option set
// - control register resets to 7Fh
// - hardware option keeps watchdog always active
// - slow and wait modes leave watchdog untouched
// - plain halt: one decrement, stop, block timeout resets
// - external interrupt resumes after 256/4096 clocks
// - reset after plain halt returns disabled state
// - halt with halt-reset option gives reset
// - halt with realtime interrupt freezes counter
// - active-halt wake: interrupt immediate, reset delayed
// - first decrement delay depends on time base
// - counter runs even while disabled
// - write activate with top bit clear resets
// - watchdog reset pulls pin low about 30us
`include "wdg_regs.vh"

module windowed_watchdog_timer #(
  parameter TICK_CYCLES = `WDG_TICK_CYCLES
) (
  // clock and reset
  input wire CLK_SYS_I,
  input wire SYS_RST_I,
  // register port
  input wire [7:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output wire [7:0] RDATA_O,
  // option bits
  input wire HW_WATCHDOG_OPT_I,
  input wire HALT_RESET_OPT_I,
  input wire RESTART_LONG_I,
  // clock controller
  input wire REALTIME_INTERRUPT_ENABLE_I,
  input wire [1:0] TIME_BASE_SELECT_I,
  // power and wake events
  input wire HALT_ENTRY_I,
  input wire EXT_INT_I,
  input wire OSC_INT_I,
  // reset pin, open drain
  output wire RST_PIN_O,
  output wire RST_PIN_OE_O,
  // status
  output wire WDG_ACTIVE_O,
  output wire WDG_HALTED_O,
  output wire RESET_REQ_O,
  output wire [1:0] RESET_CAUSE_O
);

  // ==========================================================
  // states
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_HALT = 3'h1;
  localparam [2:0] ST_ACT_HALT = 3'h2;
  localparam [2:0] ST_RESTART = 3'h3;

  localparam [1:0] CAUSE_NONE = 2'h0;
  localparam [1:0] CAUSE_TIMEOUT = 2'h1;
  localparam [1:0] CAUSE_SOFTWARE = 2'h2;
  localparam [1:0] CAUSE_HALT = 2'h3;

  localparam [12:0] RESTART_SHORT = `WDG_RESTART_SHORT;
  localparam [12:0] RESTART_LONG = `WDG_RESTART_LONG;

  // ==========================================================
  // declarations
  reg watchdog_activate_reg;
  reg watchdog_activate_next;
  reg [6:0] counter_reg;
  reg [6:0] counter_next;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [12:0] delay_reg;
  reg [12:0] delay_next;
  reg [7:0] rdata_reg;
  reg [7:0] rdata_next;
  reg [1:0] cause_reg;
  reg [1:0] cause_next;
  reg reset_req;
  reg [1:0] req_cause;
  wire ctrl_hit;
  wire ctrl_write;
  wire active;
  wire tick;
  wire counting;
  wire expire;
  wire soft_reset;
  wire pin_active;
  wire [12:0] restart_len;

  // ==========================================================
  // decode
  assign ctrl_hit = (ADDR_I == `WDG_CTRL_ADDR);
  assign ctrl_write = WR_I && ctrl_hit;

  assign active = watchdog_activate_reg || HW_WATCHDOG_OPT_I;

  assign restart_len = RESTART_LONG_I ? RESTART_LONG : RESTART_SHORT;

  // the divider runs only in the run state, not in the halts or the restart delay;
  // slow and wait modes do not reach this block at all
  assign counting = (state_reg == ST_RUN);

  // ==========================================================
  // time base
  wdg_time_base #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_time_base (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .run_i(counting),
    .reload_i(ctrl_write),
    .time_base_sel_i(TIME_BASE_SELECT_I),
    .tick_o(tick)
  );

  // ==========================================================
  // reset sources
  assign expire = tick && active && (counter_reg == `WDG_EXPIRE_VAL) && !ctrl_write;
  assign soft_reset = ctrl_write && (WDATA_I[`WDG_ACT_BIT] || active)
    && !WDATA_I[`WDG_TOP_BIT];

  always @*
  begin
    reset_req = 1'b0;
    req_cause = CAUSE_NONE;
    if (soft_reset)
    begin
      reset_req = 1'b1;
      req_cause = CAUSE_SOFTWARE;
    end
    else if (expire && counting)
    begin
      reset_req = 1'b1;
      req_cause = CAUSE_TIMEOUT;
    end
    else if (HALT_ENTRY_I && (state_reg == ST_RUN)
      && !REALTIME_INTERRUPT_ENABLE_I && HALT_RESET_OPT_I)
    begin
      reset_req = 1'b1;
      req_cause = CAUSE_HALT;
    end
  end

  // ==========================================================
  // control register and counter
  always @*
  begin
    watchdog_activate_next = watchdog_activate_reg;
    counter_next = counter_reg;
    if (ctrl_write)
    begin
      // a write of zero cannot clear the activate bit
      watchdog_activate_next = watchdog_activate_reg | WDATA_I[`WDG_ACT_BIT];
      counter_next = WDATA_I[6:0];
    end
    else if (tick && counting)
      counter_next = counter_reg - 7'h01;
    else if (HALT_ENTRY_I && (state_reg == ST_RUN)
      && !REALTIME_INTERRUPT_ENABLE_I && !HALT_RESET_OPT_I)
      counter_next = counter_reg - 7'h01;
  end

  // ==========================================================
  // power mode sequencing
  always @*
  begin
    state_next = state_reg;
    delay_next = delay_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (HALT_ENTRY_I && !reset_req)
        begin
          if (REALTIME_INTERRUPT_ENABLE_I)
            state_next = ST_ACT_HALT;
          else if (!HALT_RESET_OPT_I)
            state_next = ST_HALT;
        end
      end
      ST_HALT:
      begin
        // counter stopped and no timeout reset possible until woken; a control write can still give a software reset
        if (EXT_INT_I)
        begin
          state_next = ST_RESTART;
          delay_next = restart_len;
        end
      end
      ST_ACT_HALT:
      begin
        if (EXT_INT_I || OSC_INT_I)
          state_next = ST_RUN;
      end
      ST_RESTART:
      begin
        if (delay_reg <= 13'h0001)
        begin
          state_next = ST_RUN;
          delay_next = 13'h0000;
        end
        else
          delay_next = delay_reg - 13'h0001;
      end
      default:
      begin
        state_next = ST_RUN;
        delay_next = 13'h0000;
      end
    endcase
  end

  // ==========================================================
  // register read, data valid the cycle after the strobe
  always @*
  begin
    rdata_next = 8'h00;
    if (RD_I && ctrl_hit)
      rdata_next = {watchdog_activate_reg, counter_reg};
  end

  always @*
  begin
    cause_next = cause_reg;
    if (reset_req)
      cause_next = req_cause;
  end

  // ==========================================================
  // flops
  always @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      // any reset disables the watchdog again, plain halt or not
      watchdog_activate_reg <= 1'b0;
      counter_reg <= 7'h7f;
      // oscillator settling after reset delays counting
      state_reg <= ST_RESTART;
      delay_reg <= RESTART_SHORT;
      rdata_reg <= 8'h00;
      cause_reg <= CAUSE_NONE;
    end
    else
    begin
      watchdog_activate_reg <= watchdog_activate_next;
      counter_reg <= counter_next;
      state_reg <= state_next;
      delay_reg <= delay_next;
      rdata_reg <= rdata_next;
      cause_reg <= cause_next;
    end
  end

  // ==========================================================
  // reset pin
  wdg_reset_stretch #(
    .LENGTH(`WDG_RST_PULSE_CYC)
  ) u_reset_stretch (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .trigger_i(reset_req),
    .active_o(pin_active)
  );

  // ==========================================================
  // outputs
  assign RDATA_O = rdata_reg;
  assign RST_PIN_O = 1'b0;
  assign RST_PIN_OE_O = pin_active;
  assign WDG_ACTIVE_O = active;
  assign WDG_HALTED_O = (state_reg == ST_HALT) || (state_reg == ST_ACT_HALT);
  assign RESET_REQ_O = reset_req;
  assign RESET_CAUSE_O = cause_reg;

endmodule // windowed_watchdog_timer

// file: verif/windowed_watchdog_timer_assertions.sv
`include "wdg_regs.vh"

module wdg_checker (
  // clock and reset
  input wire CLK_SYS_I,
  input wire SYS_RST_I,
  // register port and options
  input wire [7:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire HW_WATCHDOG_OPT_I,
  input wire HALT_RESET_OPT_I,
  input wire REALTIME_INTERRUPT_ENABLE_I,
  input wire HALT_ENTRY_I,
  // watched outputs
  input wire RST_PIN_OE_O,
  input wire WDG_ACTIVE_O,
  input wire WDG_HALTED_O,
  input wire RESET_REQ_O,
  input wire [1:0] RESET_CAUSE_O
);
  // ========
  // helpers
  logic [12:0] len_reg;
  wire wr_ctl = WR_I && ADDR_I == 8'h2a;
  wire halt_run = HALT_ENTRY_I && !WDG_HALTED_O && !RST_PIN_OE_O;
  // cycles the pin has been driven so far
  always @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I || !RST_PIN_OE_O)
      len_reg <= 13'h0;
    else
      len_reg <= len_reg + 13'h1;
  end
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SYS_RST_I);
  // ========
  // properties
  property p_sticky; WDG_ACTIVE_O && !HW_WATCHDOG_OPT_I |=> WDG_ACTIVE_O; endproperty
  a_sticky: assert property (p_sticky) else $error("enable lost");
  property p_set; wr_ctl && WDATA_I[7] |=> WDG_ACTIVE_O; endproperty
  a_set: assert property (p_set) else $error("enable not set");
  property p_quiet; !WDG_ACTIVE_O && !HALT_ENTRY_I && !WR_I |-> !RESET_REQ_O; endproperty
  a_quiet: assert property (p_quiet) else $error("reset while off");
  property p_soft;
    wr_ctl && WDATA_I[7:6] == 2'b10 && !RST_PIN_OE_O |-> RESET_REQ_O ##1 RESET_CAUSE_O == 2'd2;
  endproperty
  a_soft: assert property (p_soft) else $error("no soft reset");
  property p_halt_rst;
    halt_run && !REALTIME_INTERRUPT_ENABLE_I && HALT_RESET_OPT_I
      |-> RESET_REQ_O ##1 (RST_PIN_OE_O && RESET_CAUSE_O == 2'd3);
  endproperty
  a_halt_rst: assert property (p_halt_rst) else $error("no halt reset");
  property p_nap; halt_run && REALTIME_INTERRUPT_ENABLE_I |-> !RESET_REQ_O ##1 WDG_HALTED_O; endproperty
  a_nap: assert property (p_nap) else $error("no active halt");
  property p_blocked; WDG_HALTED_O && !WR_I |-> !RESET_REQ_O; endproperty
  a_blocked: assert property (p_blocked) else $error("reset in halt");
  property p_pulse; $fell(RST_PIN_OE_O) |-> len_reg == `WDG_RST_PULSE_CYC; endproperty
  a_pulse: assert property (p_pulse) else $error("bad pulse length");
  c_timeout: cover property ($rose(RESET_CAUSE_O == 2'd1));
  c_soft: cover property (wr_ctl && WDATA_I[7:6] == 2'b10);
  c_halt: cover property ($rose(WDG_HALTED_O));
endmodule // wdg_checker

bind windowed_watchdog_timer wdg_checker u_wdg_checker (.*);

// file: verif/windowed_watchdog_timer_bench.sv
module windowed_watchdog_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // stimulus and observation
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, hw = 1'b0, hro = 1'b0;
  logic rtie = 1'b0, hlt = 1'b0, ext = 1'b0, osc = 1'b0, lng = 1'b0;
  logic [1:0] tbs = 2'h0;
  wire pin;
  logic [7:0] addr = 8'h00, wdat = 8'h00, last;
  wire [7:0] rdat;
  wire [1:0] cause;
  wire oe, act, halted;
  // status byte: active, pin drive, halted, cause
  wire [7:0] st = {3'h0, act, oe, halted, cause};
  int miscompares = 0, compares = 0, n;

  initial forever #4 clk = ~clk;

  windowed_watchdog_timer #(.TICK_CYCLES(256)) u_windowed_watchdog_timer (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdat),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .HW_WATCHDOG_OPT_I(hw),
    .HALT_RESET_OPT_I(hro), .RESTART_LONG_I(lng),
    .REALTIME_INTERRUPT_ENABLE_I(rtie), .TIME_BASE_SELECT_I(tbs),
    .HALT_ENTRY_I(hlt), .EXT_INT_I(ext), .OSC_INT_I(osc), .RST_PIN_O(pin),
    .RST_PIN_OE_O(oe), .WDG_ACTIVE_O(act), .WDG_HALTED_O(halted),
    .RESET_REQ_O(), .RESET_CAUSE_O(cause)
  );

  // ========
  // tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("%0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // hw, hro and rtie options are changed here while reset is held; lng and tbs are set elsewhere
  task automatic reset_dut(input logic [2:0] o);
    @(posedge clk);
    rst <= 1'b1;
    {hw, hro, rtie} <= o;
    cyc(4);
    rst <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 last = rdat;
  endtask

  // bits: halt entry, external wake, oscillator wake
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    {hlt, ext, osc} <= m;
    @(posedge clk);
    {hlt, ext, osc} <= 3'b000;
  endtask

  task automatic expect_reset(input logic [7:0] s);
    n = 0;
    while (oe !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk(st, s);
    chk({7'h00, pin}, 8'h00);
    if (n == 3000)
    begin
      miscompares++;
      disable main_seq;
    end
    n = 0;
    while (oe === 1'b1 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    chk(n[15:8], 8'h0e);
    chk(n[7:0], 8'ha6);
    if (n == 5000)
    begin
      miscompares++;
      disable main_seq;
    end
  endtask

  // ========
  // main sequence
  initial
  begin
    begin : main_seq
    reset_dut(3'b000);
    rreg(8'h2a);
    chk(last, 8'h7f);
    wreg(8'h2b, 8'h00);
    rreg(8'h2b);
    chk(last, 8'h00);
    rreg(8'h2a);
    chk(last, 8'h7f);
    wreg(8'h2a, 8'hc5);
    rreg(8'h2a);
    chk(last, 8'hc5);
    wreg(8'h2a, 8'h45);
    rreg(8'h2a);
    chk(last, 8'hc5);
    wreg(8'h2a, 8'hc1);
    expect_reset(8'h19);
    reset_dut(3'b000);
    wreg(8'h2a, 8'h41);
    cyc(1500);
    rreg(8'h2a);
    chk(last & 8'hc0, 8'h00);
    chk(st, 8'h00);
    for (int h = 0; h < 2; h++)
    begin
      reset_dut({h[0], 2'b00});
      wreg(8'h2a, h[0] ? 8'h00 : 8'h80);
      expect_reset(8'h1a);
    end
    reset_dut(3'b010);
    cyc(300);
    pulse(3'b100);
    expect_reset(8'h0b);
    reset_dut(3'b000);
    cyc(300);
    wreg(8'h2a, 8'hff);
    pulse(3'b100);
    rreg(8'h2a);
    chk(last, 8'hfe);
    cyc(2000);
    rreg(8'h2a);
    chk(last, 8'hfe);
    chk(st, 8'h14);
    pulse(3'b010);
    cyc(150);
    rreg(8'h2a);
    chk(last, 8'hfe);
    chk(st, 8'h10);
    cyc(400);
    rreg(8'h2a);
    chk({7'h00, last < 8'hfe}, 8'h01);
    pulse(3'b100);
    reset_dut(3'b000);
    rreg(8'h2a);
    chk(last, 8'h7f);
    chk(st, 8'h00);
    lng <= 1'b1;
    cyc(300);
    wreg(8'h2a, 8'hff);
    pulse(3'b100);
    pulse(3'b010);
    cyc(2000);
    rreg(8'h2a);
    chk(last, 8'hfe);
    cyc(2500);
    rreg(8'h2a);
    chk({7'h00, last < 8'hfe}, 8'h01);
    lng <= 1'b0;
    reset_dut(3'b001);
    tbs <= 2'h3;
    cyc(300);
    wreg(8'h2a, 8'hff);
    cyc(150);
    rreg(8'h2a);
    chk(last, 8'hff);
    wreg(8'h2a, 8'hff);
    pulse(3'b100);
    cyc(1000);
    rreg(8'h2a);
    chk(last, 8'hff);
    chk(st, 8'h14);
    pulse(3'b001);
    cyc(300);
    rreg(8'h2a);
    chk(last, 8'hfe);
    chk(st, 8'h10);
    end
    print_verdict;
  end
endmodule // windowed_watchdog_timer_bench
